// >>> tco_cfg.svh
// Offsets, field positions, reset values and timing counts of the tandem overhead block
`ifndef TCO_CFG_SVH
`define TCO_CFG_SVH
`define TCO_FRAME_LEN     10'd537
`define TCO_EM_POS        10'd118
`define TCO_NR_POS        10'd298
`define TCO_MF_LEN        7'd76
`define TCO_FAS_LAST      7'd8
`define TCO_TRACE_LAST    7'd72
`define TCO_RDI_FRAME     7'd73
`define TCO_ODI_FRAME     7'd74
`define TCO_FAS_WORD      16'hfffe
`define TCO_IEC_SF        4'he
`define TCO_IEC_ZERO      4'h9
`define TCO_MF_TIME_US    9500
`define TCO_CLK_MHZ       25
`define TCO_REG_CTRL      8'h00
`define TCO_REG_IRQ_STAT  8'h04
`define TCO_REG_IRQ_MASK  8'h08
`define TCO_REG_SINK_STAT 8'h0c
`define TCO_REG_TRACE0    8'h10
`define TCO_REG_TRACE3    8'h1c
`define TCO_CTRL_RESET    32'h0000_0001
`define TCO_IRQ_ERR_BIT   0
`define TCO_IRQ_AIS_BIT   1
`define TCO_IRQ_VIOL_BIT  2
`endif

// >>> tco_pkg.sv
// Types of the tandem overhead block
package tco_pkg;
   typedef enum logic [2:0] {SLOT_FAS, SLOT_TRACE, SLOT_RDI, SLOT_ODI, SLOT_SPARE} tco_slot_t;
   typedef logic [7:0] tco_byte_t;
endpackage : tco_pkg

// >>> tco_overhead.sv
// Tandem connection overhead source and sink with Wishbone register slave
`timescale 1ns/1ns
`default_nettype none
`include "tco_cfg.svh"
module tco_overhead
   import tco_pkg::*;
#(
   parameter int MF_CYCLES = `TCO_MF_TIME_US * `TCO_CLK_MHZ
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o,
   output logic             irq_o,
   input  wire logic        link_clk_i,
   input  wire logic        src_fs_i,
   input  wire logic [7:0]  src_data_i,
   input  wire logic        snk_fs_i,
   input  wire logic [7:0]  snk_data_i,
   input  wire logic        remote_defect_request_i,
   input  wire logic        remote_error_request_i,
   input  wire logic        outgoing_defect_request_i,
   input  wire logic        outgoing_error_request_i,
   input  wire logic        incoming_signal_fail_i,
   output logic      [7:0]  src_data_o,
   output logic             src_fs_o,
   output logic             src_strobe_o,
   output logic             errored_tandem_block_o,
   output logic             incoming_alarm_flag_o,
   output logic      [3:0]  outgoing_error_count_o
);

   function automatic logic [3:0] popcnt(input logic [7:0] v);
      logic [3:0] n;
      n = 4'h0;
      for (int k = 0; k < 8; k++) begin
         n = n + {3'b000, v[k]};
      end
      return n;
   endfunction : popcnt

   function automatic tco_slot_t slot_of(input logic [6:0] f);
      if (f <= `TCO_FAS_LAST) begin
         return SLOT_FAS;
      end else if (f <= `TCO_TRACE_LAST) begin
         return SLOT_TRACE;
      end else if (f == `TCO_RDI_FRAME) begin
         return SLOT_RDI;
      end else if (f == `TCO_ODI_FRAME) begin
         return SLOT_ODI;
      end
      return SLOT_SPARE;
   endfunction : slot_of

   // Link synchronisers
   logic [2:0]  lclk_q;
   logic [1:0]  sfs_q;
   logic [1:0]  kfs_q;
   logic [7:0]  sd1_q, sd2_q, kd1_q, kd2_q;
   wire  logic  lstb = lclk_q[1] & ~lclk_q[2];
   always_ff @(posedge clk_i) begin
      lclk_q <= {lclk_q[1:0], link_clk_i};
      sfs_q  <= {sfs_q[0], src_fs_i};
      kfs_q  <= {kfs_q[0], snk_fs_i};
      sd1_q  <= src_data_i;
      sd2_q  <= sd1_q;
      kd1_q  <= snk_data_i;
      kd2_q  <= kd1_q;
   end

   // Registers
   logic [31:0]  ctrl_q;
   logic [2:0]   irq_stat_q, irq_mask_q;
   logic [127:0] trace_q;
   logic         ack_q;
   logic [31:0]  rdata;
   logic [15:0]  err_blk_cnt_q;
   logic [3:0]   snk_dec_q;
   wire  logic   wb_req  = wb_cyc_i & wb_stb_i & ~ack_q;
   wire  logic   wb_wr   = wb_req & wb_we_i;
   wire  logic   insert_en = ctrl_q[0];
   wire  logic [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire  logic   hit_trace = (wb_adr_i >= `TCO_REG_TRACE0) && (wb_adr_i <= `TCO_REG_TRACE3) && (wb_adr_i[1:0] == 2'b00);
   wire  logic [1:0] trace_w = 2'd3 - wb_adr_i[3:2];
   logic [2:0]   irq_set;

   always_comb begin
      if (wb_adr_i == `TCO_REG_CTRL) begin
         rdata = ctrl_q;
      end else if (wb_adr_i == `TCO_REG_IRQ_STAT) begin
         rdata = {29'h0, irq_stat_q};
      end else if (wb_adr_i == `TCO_REG_IRQ_MASK) begin
         rdata = {29'h0, irq_mask_q};
      end else if (wb_adr_i == `TCO_REG_SINK_STAT) begin
         rdata = {err_blk_cnt_q, 7'h0, incoming_alarm_flag_o, snk_dec_q, outgoing_error_count_o};
      end else if (hit_trace) begin
         rdata = trace_q[32*trace_w +: 32];
      end else begin
         rdata = 32'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q    <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         ack_q    <= wb_req;
         wb_dat_o <= wb_req ? rdata : 32'h0;
      end
   end
   assign wb_ack_o = ack_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q     <= `TCO_CTRL_RESET;
         irq_mask_q <= 3'h0;
         trace_q    <= 128'h0;
      end else if (wb_wr) begin
         if (wb_adr_i == `TCO_REG_CTRL) begin
            ctrl_q <= (ctrl_q & ~wmask) | (wb_dat_i & wmask);
         end else if (wb_adr_i == `TCO_REG_IRQ_MASK) begin
            irq_mask_q <= wb_sel_i[0] ? wb_dat_i[2:0] : irq_mask_q;
         end else if (hit_trace) begin
            trace_q[32*trace_w +: 32] <= (trace_q[32*trace_w +: 32] & ~wmask) | (wb_dat_i & wmask);
         end
      end
   end

   // Set wins over write-one clear
   wire logic irq_clr_wr = wb_wr && (wb_adr_i == `TCO_REG_IRQ_STAT) && wb_sel_i[0];
   wire logic [2:0] irq_clr = irq_clr_wr ? wb_dat_i[2:0] : 3'h0;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= 3'h0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      end
   end
   assign irq_o = |(irq_stat_q & irq_mask_q);

   // Source side
   wire  logic [7:0] s_din   = sd2_q;
   wire  logic       s_fs    = sfs_q[1];
   logic [9:0]  s_idx_q;
   logic [6:0]  mf_q;
   logic [7:0]  s_acc_q, s_bip_q, comp_q;
   logic [7:0]  em_in_q, em_out_q, nr_in_q, nr_out_q;
   logic        rdi_q, odi_q, rei_q, oei_q;
   logic [3:0]  iec_q;
   wire  logic [9:0] s_idx   = s_fs ? 10'd0 : s_idx_q + 10'd1;
   wire  logic [6:0] mf_next = (mf_q == `TCO_MF_LEN) ? 7'd1 : mf_q + 7'd1;
   wire  logic [6:0] mf_cur  = s_fs ? mf_next : mf_q;
   wire  logic       at_em   = (s_idx == `TCO_EM_POS);
   wire  logic       at_nr   = (s_idx == `TCO_NR_POS);
   wire  logic [3:0] s_viol  = popcnt(s_din ^ s_bip_q);
   wire  logic [3:0] iec_new = incoming_signal_fail_i ? `TCO_IEC_SF :
                               (s_viol == 4'h0) ? `TCO_IEC_ZERO : s_viol;
   wire  logic [7:0] em_new  = insert_en ? (s_din ^ comp_q) : s_din;
   wire  logic [6:0] tr_bit  = 7'(2 * (mf_cur - 7'd9));
   logic [1:0]  mf_bits;
   always_comb begin
      case (slot_of(mf_cur))
         SLOT_FAS:   mf_bits = 2'(`TCO_FAS_WORD >> (5'd16 - 5'(2 * mf_cur)));
         SLOT_TRACE: mf_bits = {trace_q[7'd127 - tr_bit], trace_q[7'd126 - tr_bit]};
         SLOT_RDI:   mf_bits = {1'b0, rdi_q};
         SLOT_ODI:   mf_bits = {odi_q, 1'b0};
         default:    mf_bits = 2'b00;
      endcase
   end
   wire  logic [7:0] nr_new = insert_en ? {iec_q, rei_q, oei_q, mf_bits} : s_din;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_idx_q <= `TCO_FRAME_LEN;
         mf_q    <= `TCO_MF_LEN;
         s_acc_q <= 8'h00;
         s_bip_q <= 8'h00;
         comp_q  <= 8'h00;
         {rdi_q, odi_q, rei_q, oei_q} <= 4'h0;
      end else if (lstb) begin
         s_idx_q <= s_idx;
         s_acc_q <= s_fs ? s_din : s_acc_q ^ s_din;
         if (s_fs) begin
            mf_q    <= mf_next;
            s_bip_q <= s_acc_q;
            comp_q  <= em_in_q ^ em_out_q ^ nr_in_q ^ nr_out_q;
            rdi_q   <= remote_defect_request_i;
            odi_q   <= outgoing_defect_request_i;
            rei_q   <= remote_error_request_i;
            oei_q   <= outgoing_error_request_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {em_in_q, em_out_q, nr_in_q, nr_out_q} <= 32'h0;
         iec_q <= `TCO_IEC_ZERO;
      end else if (lstb && at_em) begin
         em_in_q  <= s_din;
         em_out_q <= em_new;
         iec_q    <= iec_new;
      end else if (lstb && at_nr) begin
         nr_in_q  <= s_din;
         nr_out_q <= nr_new;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_data_o   <= 8'h00;
         src_fs_o     <= 1'b0;
         src_strobe_o <= 1'b0;
      end else begin
         src_strobe_o <= lstb;
         if (lstb) begin
            src_data_o <= at_em ? em_new : at_nr ? nr_new : s_din;
            src_fs_o   <= s_fs;
         end
      end
   end

   // Sink side
   wire  logic [7:0] k_din = kd2_q;
   wire  logic       k_fs  = kfs_q[1];
   logic [9:0]  k_idx_q;
   logic [7:0]  k_acc_q, k_bip_q;
   logic        k_err_q, k_ais_q;
   wire  logic [9:0] k_idx  = k_fs ? 10'd0 : k_idx_q + 10'd1;
   wire  logic [3:0] k_iec  = k_din[7:4];
   wire  logic [3:0] k_dec  = (k_iec >= 4'h1 && k_iec <= 4'h8) ? k_iec : 4'h0;
   wire  logic [3:0] k_diff = (outgoing_error_count_o > k_dec) ?
                              outgoing_error_count_o - k_dec : k_dec - outgoing_error_count_o;
   wire  logic       k_at_nr = lstb && (k_idx == `TCO_NR_POS);
   wire  logic       k_blk   = k_at_nr && (k_diff != 4'h0);
   wire  logic       k_ais   = (k_iec == `TCO_IEC_SF);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         k_idx_q <= `TCO_FRAME_LEN;
         k_acc_q <= 8'h00;
         k_bip_q <= 8'h00;
         outgoing_error_count_o <= 4'h0;
      end else if (lstb) begin
         k_idx_q <= k_idx;
         k_acc_q <= k_fs ? k_din : k_acc_q ^ k_din;
         if (k_fs) begin
            k_bip_q <= k_acc_q;
         end
         if (k_idx == `TCO_EM_POS) begin
            outgoing_error_count_o <= popcnt(k_din ^ k_bip_q);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         errored_tandem_block_o <= 1'b0;
         incoming_alarm_flag_o  <= 1'b0;
         snk_dec_q              <= 4'h0;
         err_blk_cnt_q          <= 16'h0;
      end else begin
         errored_tandem_block_o <= k_blk;
         if (k_at_nr) begin
            incoming_alarm_flag_o <= k_ais;
            snk_dec_q             <= k_dec;
            err_blk_cnt_q         <= err_blk_cnt_q + {15'h0, k_blk};
         end
      end
   end

   assign irq_set = {lstb && at_em && (s_viol != 4'h0), k_at_nr && k_ais, k_blk};

   // Checks
   logic [31:0] rdi_wait_q;
   wire  logic  rdi_slot = lstb && at_nr && (mf_cur == `TCO_RDI_FRAME);
   always_ff @(posedge clk_i) begin
      if (rst_i || !remote_defect_request_i || !insert_en || rdi_slot) begin
         rdi_wait_q <= 32'h0;
      end else begin
         rdi_wait_q <= rdi_wait_q + 32'h1;
      end
   end

   sequence nr_byte_s;
      lstb && at_nr && insert_en;
   endsequence

   ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   rdi_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rdi_wait_q <= MF_CYCLES) else $error("remote defect not sent in time");
   rdi_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      nr_byte_s and (mf_cur == `TCO_RDI_FRAME) |=> src_data_o[1:0] == {1'b0, rdi_q})
      else $error("frame 73 bits wrong");
   odi_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      nr_byte_s and (mf_cur == `TCO_ODI_FRAME) |=> src_data_o[1:0] == {odi_q, 1'b0})
      else $error("frame 74 bits wrong");
   fas_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
      nr_byte_s and (mf_cur <= 7'd7) |=> src_data_o[1:0] == 2'b11) else $error("alignment word wrong");
   fas_end_a: assert property (@(posedge clk_i) disable iff (rst_i)
      nr_byte_s and (mf_cur == 7'd8) |=> src_data_o[1:0] == 2'b10) else $error("alignment end wrong");
   spare_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      nr_byte_s and (mf_cur > `TCO_ODI_FRAME) |=> src_data_o[1:0] == 2'b00) else $error("spare bits set");
   sf_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
      lstb && at_em && incoming_signal_fail_i |=> iec_q == 4'he) else $error("signal fail code missing");
   zero_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
      lstb && at_em && !incoming_signal_fail_i && s_din == s_bip_q |=> iec_q == 4'h9)
      else $error("zero count code wrong");
   em_comp_a: assert property (@(posedge clk_i) disable iff (rst_i)
      lstb && at_em && insert_en |=> src_data_o == ($past(s_din, 1) ^ comp_q)) else $error("parity not compensated");
   mf_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      lstb && s_fs && mf_q == `TCO_MF_LEN |=> mf_q == 7'd1) else $error("multiframe did not wrap");
   blk_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      k_at_nr && (k_dec != outgoing_error_count_o) |=> errored_tandem_block_o ##1 !errored_tandem_block_o)
      else $error("errored block not flagged");
   irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(irq_stat_q[0]) && irq_mask_q[0] |-> irq_o) else $error("interrupt not raised");
endmodule : tco_overhead
`default_nettype wire

// >>> tco_link_partner.sv
// Link-side partner: byte clock and frame stream towards the block
`timescale 1ns/1ns
`default_nettype none
module tco_link_partner
   import tco_pkg::*;
(
   output logic      link_clk_o,
   output logic      fs_o,
   output tco_byte_t data_o
);
   initial begin
      link_clk_o = 1'b0;
      fs_o       = 1'b0;
      data_o     = 8'h00;
   end
   // One frame; byte clock stands still and data goes stale after the last
   task automatic send_frame(input tco_byte_t fr [0:536], input bit last);
      #7;
      for (int i = 0; i < 537; i++) begin
         link_clk_o = 1'b0;
         data_o     = fr[i];
         fs_o       = (i == 0);
         #160;
         link_clk_o = 1'b1;
         #160;
      end
      link_clk_o = 1'b0;
      if (last) begin
         data_o = ~data_o;
         fs_o   = 1'b0;
      end
   endtask : send_frame
endmodule : tco_link_partner
`default_nettype wire

// >>> tco_overhead_tb.sv
// Self-checking testbench of the tandem overhead block
`timescale 1ns/1ns
`default_nettype none
`include "tco_cfg.svh"
module tco_overhead_tb
   import tco_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_we_i = 1'b0;
   logic [3:0]  wb_sel_i = 4'h0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_ack_o;
   logic        irq_o;
   logic        link_clk_i;
   logic        src_fs_i;
   tco_byte_t   src_data_i;
   logic        snk_fs_i;
   tco_byte_t   snk_data_i;
   logic [4:0]  rq = 5'h0;
   logic        sf = 1'b0;
   tco_byte_t   src_data_o;
   logic        src_fs_o;
   logic        src_strobe_o;
   logic        errored_tandem_block_o;
   logic        incoming_alarm_flag_o;
   logic [3:0]  outgoing_error_count_o;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cyc_n = 0;
   int          idx = 0;
   int          fno = 0;
   logic [8:0]  exp_q [$];
   logic [5:0]  snk_q [$];

   assign snk_fs_i   = src_fs_i;
   assign snk_data_i = src_data_i;

   tco_link_partner partner (.link_clk_o(link_clk_i), .fs_o(src_fs_i), .data_o(src_data_i));

   tco_overhead DUT (
      .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
      .wb_ack_o, .irq_o, .link_clk_i, .src_fs_i, .src_data_i, .snk_fs_i, .snk_data_i,
      .remote_defect_request_i(rq[0]), .remote_error_request_i(rq[1]),
      .outgoing_defect_request_i(rq[2]), .outgoing_error_request_i(rq[3]),
      .incoming_signal_fail_i(sf), .src_data_o, .src_fs_o, .src_strobe_o,
      .errored_tandem_block_o, .incoming_alarm_flag_o, .outgoing_error_count_o
   );

   initial begin
      forever #20 clk_i = ~clk_i;
   end

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   // Classic single Wishbone cycle, held until ack is sampled or 20 cycles pass
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (n >= 20) n_mismatch++;
   endtask : wb

   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 90000) begin
         n_mismatch++;
         conclude();
      end
   end

   // Output watcher: every byte against the oldest note
   always @(negedge clk_i) begin
      logic [8:0] ex;
      logic [5:0] sx;
      if (src_strobe_o === 1'b1) begin
         if (src_fs_o === 1'b1) begin
            idx = 0;
            fno++;
         end else idx++;
         ex = exp_q.pop_front();
         check("frame start", 8'(src_fs_o), 8'(ex[8]));
         if (idx == 298) begin
            check("error code", 8'(src_data_o[7:4]), 8'(ex[7:4]));
            check("error bits", 8'(src_data_o[3:2]), 8'(ex[3:2]));
            check("multiframe bits", 8'(src_data_o[1:0]), 8'(ex[1:0]));
            if (fno > 1) begin
               sx = snk_q.pop_front();
               check("errored block", 8'(errored_tandem_block_o), 8'(sx[5]));
               check("alarm flag", 8'(incoming_alarm_flag_o), 8'(sx[4]));
               check("error count", 8'(outgoing_error_count_o), 8'(sx[3:0]));
            end
         end else if (idx == 118) begin
            check("parity byte", src_data_o, ex[7:0]);
         end else check("payload byte", src_data_o, ex[7:0]);
      end
   end

   initial begin
      logic [31:0]  q;
      logic [127:0] trace;
      tco_byte_t    fr [0:536];
      tco_byte_t    bip, mask, xe, xn, pen, pnr, pxe, pxn;
      logic [3:0]   k, code, dec, xc;
      logic [4:0]   r;
      void'($urandom(32'hc68bdb34));
      bip = 8'h00;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h00, 32'h0, q);
      check("ctrl reset", q[7:0], 8'h01);
      wb(1'b0, 8'h40, 32'h0, q);
      check("unmapped read", q[7:0], 8'h00);
      wb(1'b1, 8'h08, 32'h1, q);
      wb(1'b0, 8'h08, 32'h0, q);
      check("irq mask", q[7:0], 8'h01);
      trace = {$urandom, $urandom, $urandom, $urandom};
      for (int i = 0; i < 4; i++) wb(1'b1, 8'(8'h10 + 4 * i), trace[127 - 32 * i -: 32], q);
      $display("register test done");
      for (int t = 1; t <= 17; t++) begin
         k    = (t < 2) ? 4'h0 : 4'((t - 2) % 9);
         code = 4'((t + 14) % 16);
         mask = 8'((9'h1 << k) - 9'h1);
         for (int i = 0; i < 537; i++) fr[i] = 8'($urandom);
         fr[118]      = bip ^ mask;
         fr[298][7:4] = code;
         r = 5'($urandom);
         @(posedge clk_i);
         rq <= r;
         sf <= (t == 1 || t == 6);
         xc = (t == 1 || t == 6) ? `TCO_IEC_SF : ((k == 4'h0) ? `TCO_IEC_ZERO : k);
         xn = {xc, r[1], r[3], (t <= 8) ? 2'(16'hfffe >> (16 - 2 * t)) : 2'(trace >> (126 - 2 * (t - 9)))};
         xe = (t == 1) ? fr[118] : (pen ^ pxe ^ pnr ^ pxn ^ fr[118]);
         bip = 8'h00;
         for (int i = 0; i < 537; i++) begin
            exp_q.push_back({i == 0, (i == 118) ? xe : ((i == 298) ? xn : fr[i])});
            bip ^= fr[i];
         end
         dec = (code >= 4'h1 && code <= 4'h8) ? code : 4'h0;
         if (t >= 2) snk_q.push_back({k != dec, code == 4'he, k});
         pen = fr[118];
         pnr = fr[298];
         pxe = xe;
         pxn = xn;
         partner.send_frame(fr, t == 17);
      end
      repeat (20) @(posedge clk_i);
      check("irq raised", 8'(irq_o), 8'h01);
      check("notes left", 8'(exp_q.size() + snk_q.size()), 8'h00);
      wb(1'b1, 8'h04, 32'h7, q);
      @(posedge clk_i);
      check("irq cleared", 8'(irq_o), 8'h00);
      $display("frame test done");
      conclude();
   end
endmodule : tco_overhead_tb
`default_nettype wire
